// >>> core/sccfg_pkg.sv
package sccfg_pkg;
   // =====================================================
   // register offsets
   localparam logic [7:0] SCCFG_OFS_SLOT_FIFO = 8'h11;
   localparam logic [7:0] SCCFG_OFS_PERIOD = 8'h12;
   localparam logic [7:0] SCCFG_OFS_SYNC_GATE = 8'h38;
   localparam logic [7:0] SCCFG_OFS_CLK_CTRL = 8'h4b;
   localparam logic [7:0] SCCFG_OFS_RSV_HIGH = 8'h4d;
   localparam logic [7:0] SCCFG_OFS_SYNC_SEL = 8'h4f;

   // =====================================================
   // reset values
   localparam logic [15:0] SCCFG_RST_SLOT_FIFO = 16'h0000;
   localparam logic [15:0] SCCFG_RST_PERIOD = 16'h0028;
   localparam logic [15:0] SCCFG_RST_SYNC_GATE = 16'h0000;
   localparam logic [15:0] SCCFG_RST_CLK_CTRL = 16'h2612;
   localparam logic [15:0] SCCFG_RST_RSV_HIGH = 16'h425e;
   localparam logic [15:0] SCCFG_RST_SYNC_SEL = 16'h2090;

   // =====================================================
   // field positions
   localparam int SCCFG_BIT_SLOT_EN = 0;
   localparam int SCCFG_FMT_LSB = 2;
   localparam int SCCFG_FMT_MSB = 4;
   localparam int SCCFG_BIT_EXT_GATE = 14;
   localparam int SCCFG_BIT_CLK_POWER = 7;
   localparam int SCCFG_TRIM_MSB = 5;
   localparam int SCCFG_BIT_SYNC_SEL = 2;
   localparam int SCCFG_BIT_INT_IE = 1;

   // =====================================================
   // fifo format codes
   localparam logic [2:0] SCCFG_FMT_NONE = 3'h0;
   localparam logic [2:0] SCCFG_FMT_SUM16 = 3'h1;
   localparam logic [2:0] SCCFG_FMT_SUM32 = 3'h2;
   localparam logic [2:0] SCCFG_FMT_CH16 = 3'h4;
   localparam logic [2:0] SCCFG_FMT_CH32 = 3'h6;

   // =====================================================
   // sample clock timing
   localparam int SCCFG_MCLK_HZ = 50_000_000;
   localparam int SCCFG_TRIM_CENTRE = 34;
   // nominal and step frequency in units of 100 Hz
   localparam int SCCFG_F_NOM_100HZ = 320;
   localparam int SCCFG_F_STEP_100HZ = 6;
   localparam logic [15:0] SCCFG_F_MAX_100HZ =
      16'(SCCFG_F_NOM_100HZ + SCCFG_F_STEP_100HZ * SCCFG_TRIM_CENTRE);
   localparam logic [15:0] SCCFG_F_STEP_W = 16'(SCCFG_F_STEP_100HZ);
   // phase increment per 100 Hz for a 32-bit accumulator
   localparam logic [15:0] SCCFG_INC_PER_100HZ =
      16'((64'd100 * (64'd1 << 32)) / 64'(SCCFG_MCLK_HZ));
   localparam int SCCFG_PERIOD_MULT = 4;
endpackage

// >>> core/sccfg_tick.sv
`timescale 1ns/1ps
`default_nettype none
module sccfg_tick
   import sccfg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire logic clk_power,
   input wire logic [5:0] trim,
   input wire logic [15:0] period,
   // sample pacing
   output logic clk32k_tick,
   output logic sample_tick
);
   logic [31:0] acc_q;
   logic [15:0] freq_100hz;
   logic [31:0] phase_inc;
   logic [32:0] acc_sum;
   logic [17:0] cnt_q;
   logic [17:0] limit;

   // =====================================================
   // trimmed 32 kHz clock
   // RL5: per step shift
   // RL6: inverse trim coding
   assign freq_100hz = SCCFG_F_MAX_100HZ - 16'(SCCFG_F_STEP_W * {10'h000, trim});
   assign phase_inc = {16'h0000, freq_100hz} * {16'h0000, SCCFG_INC_PER_100HZ};
   assign acc_sum = {1'b0, acc_q} + {1'b0, phase_inc};

   // RL4: clock gated off
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= 32'h0000_0000;
         clk32k_tick <= 1'b0;
      end else if (clk_power) begin
         acc_q <= acc_sum[31:0];
         clk32k_tick <= acc_sum[32];
      end else begin
         acc_q <= 32'h0000_0000;
         clk32k_tick <= 1'b0;
      end
   end

   // =====================================================
   // period divider
   // RL7: divide by four times period
   assign limit = 18'(SCCFG_PERIOD_MULT) * {2'b00, period};

   // period of zero gives no samples rather than a runaway rate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 18'h0_0000;
         sample_tick <= 1'b0;
      end else if (!clk_power || limit == 18'h0_0000) begin
         cnt_q <= 18'h0_0000;
         sample_tick <= 1'b0;
      end else if (clk32k_tick) begin
         if (cnt_q >= limit - 18'h0_0001) begin
            cnt_q <= 18'h0_0000;
            sample_tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 18'h0_0001;
            sample_tick <= 1'b0;
         end
      end else begin
         sample_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> core/sccfg_top.sv
// Behaviour
// RL1: format code 6 stores four channels of 32-bit extended data per sample.
// RL2: slot config bit 0 enables the first slot; cleared means no measurement.
// RL3: software sets bit 14 of sync_gate_control exactly when sync source select is 1.
// RL4: bit 7 of sample_clock_control gates the sample clock; 0 stops, 1 runs.
// RL5: trim bits 5..0 shift the 32 kHz clock about 0.6 kHz per step.
// RL6: trim is inverse: 0 fastest, 0x22 centre, 0x3F slowest.
// RL7: sample rate is 32 kHz divided by four times the period register.
// RL8: select 0 uses internal timing; select 1 triggers on interrupt pin pulses.
// RL9: with clock gate cleared, no internal samples and configuration kept.
`timescale 1ns/1ps
`default_nettype none
module sccfg_top
   import sccfg_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET_N,
   // register access
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   // external sync pin
   input wire logic INT_PIN,
   // sample control
   output logic SAMPLE_START,
   output logic FIRST_SLOT_ENABLE,
   output logic [2:0] FIRST_SLOT_FIFO_FORMAT,
   output logic [3:0] FIFO_WORDS_PER_SAMPLE,
   output logic FORMAT_RESERVED,
   output logic SAMPLE_CLOCK_TICK
);
   logic [15:0] slot_fifo_config_q;
   logic [15:0] period_q;
   logic [15:0] sync_gate_control_q;
   logic [15:0] sample_clock_control_q;
   logic [15:0] reserved_config_high_q;
   logic [15:0] sync_select_q;
   logic int_pin_q;
   logic first_slot_enable;
   logic sync_source_select;
   logic int_input_enable;
   logic sample_clock_power;
   logic clk32k_tick;
   logic internal_tick;
   logic ext_trigger;
   logic start_d;
   logic [5:0] wr_hit;
   logic [5:0] rd_hit;
   logic [15:0] reg_view [6];
   logic [15:0] rd_term [6];
   logic [15:0] rd_mux;

   // =====================================================
   // decoding
   function automatic logic [3:0] fmt_words(input logic [2:0] fmt);
      case (fmt)
         SCCFG_FMT_NONE: fmt_words = 4'h0;
         SCCFG_FMT_SUM16: fmt_words = 4'h1;
         SCCFG_FMT_SUM32: fmt_words = 4'h2;
         SCCFG_FMT_CH16: fmt_words = 4'h4;
         // RL1: four 32-bit channels
         SCCFG_FMT_CH32: fmt_words = 4'h8;
         default: fmt_words = 4'h0;
      endcase
   endfunction

   function automatic logic fmt_reserved(input logic [2:0] fmt);
      case (fmt)
         SCCFG_FMT_NONE, SCCFG_FMT_SUM16, SCCFG_FMT_SUM32,
         SCCFG_FMT_CH16, SCCFG_FMT_CH32: fmt_reserved = 1'b0;
         default: fmt_reserved = 1'b1;
      endcase
   endfunction

   // one-hot register select, shared by the write and read paths
   function automatic logic [5:0] reg_hit(input logic [7:0] addr);
      case (addr)
         SCCFG_OFS_SLOT_FIFO: reg_hit = 6'h01;
         SCCFG_OFS_PERIOD: reg_hit = 6'h02;
         SCCFG_OFS_SYNC_GATE: reg_hit = 6'h04;
         SCCFG_OFS_CLK_CTRL: reg_hit = 6'h08;
         SCCFG_OFS_RSV_HIGH: reg_hit = 6'h10;
         SCCFG_OFS_SYNC_SEL: reg_hit = 6'h20;
         default: reg_hit = 6'h00;
      endcase
   endfunction

   // =====================================================
   // address decode
   assign wr_hit = REG_WR ? reg_hit(REG_ADDR) : 6'h00;
   assign rd_hit = reg_hit(REG_ADDR);

   // =====================================================
   // register file
   // RL9: only software writes change configuration
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         slot_fifo_config_q <= SCCFG_RST_SLOT_FIFO;
      end else if (wr_hit[0]) begin
         slot_fifo_config_q <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         period_q <= SCCFG_RST_PERIOD;
      end else if (wr_hit[1]) begin
         period_q <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync_gate_control_q <= SCCFG_RST_SYNC_GATE;
      end else if (wr_hit[2]) begin
         sync_gate_control_q <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sample_clock_control_q <= SCCFG_RST_CLK_CTRL;
      end else if (wr_hit[3]) begin
         sample_clock_control_q <= REG_WDATA;
      end
   end

   // reserved bits kept as written so software can restore them
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         reserved_config_high_q <= SCCFG_RST_RSV_HIGH;
      end else if (wr_hit[4]) begin
         reserved_config_high_q <= REG_WDATA;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync_select_q <= SCCFG_RST_SYNC_SEL;
      end else if (wr_hit[5]) begin
         sync_select_q <= REG_WDATA;
      end
   end

   // =====================================================
   // read back
   assign reg_view[0] = slot_fifo_config_q;
   assign reg_view[1] = period_q;
   assign reg_view[2] = sync_gate_control_q;
   assign reg_view[3] = sample_clock_control_q;
   assign reg_view[4] = reserved_config_high_q;
   assign reg_view[5] = sync_select_q;

   // unmapped offsets hit nothing and read as zero
   for (genvar i = 0; i < 6; i++) begin : g_rd_term
      assign rd_term[i] = rd_hit[i] ? reg_view[i] : 16'h0000;
   end

   always_comb begin
      rd_mux = 16'h0000;
      for (int i = 0; i < 6; i++) begin
         rd_mux = rd_mux | rd_term[i];
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= 16'h0000;
      end else if (REG_RD) begin
         REG_RDATA <= rd_mux;
      end
   end

   // =====================================================
   // field extraction
   // RL2: first slot enable bit
   assign first_slot_enable = slot_fifo_config_q[SCCFG_BIT_SLOT_EN];
   assign sample_clock_power = sample_clock_control_q[SCCFG_BIT_CLK_POWER];
   assign sync_source_select = sync_select_q[SCCFG_BIT_SYNC_SEL];
   assign int_input_enable = sync_select_q[SCCFG_BIT_INT_IE];

   sccfg_tick u_tick (
      .clk(MCLK),
      .rst_n(RESET_N),
      .clk_power(sample_clock_power),
      .trim(sample_clock_control_q[SCCFG_TRIM_MSB:0]),
      .period(period_q),
      .clk32k_tick(clk32k_tick),
      .sample_tick(internal_tick)
   );

   // =====================================================
   // sample trigger selection
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         int_pin_q <= 1'b0;
      end else begin
         int_pin_q <= INT_PIN;
      end
   end

   // rising edge only; the pin is taken as synchronous
   // RL3: relies on software keeping the gate bit matched
   assign ext_trigger = INT_PIN && !int_pin_q && int_input_enable &&
      sync_gate_control_q[SCCFG_BIT_EXT_GATE];

   // RL8: internal or pin-triggered timing
   // RL9: internal ticks already stop with the clock gate
   always_comb begin
      start_d = 1'b0;
      if (first_slot_enable) begin
         start_d = sync_source_select ? ext_trigger : internal_tick;
      end
   end

   // =====================================================
   // outputs
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SAMPLE_START <= 1'b0;
         FIRST_SLOT_ENABLE <= 1'b0;
         FIRST_SLOT_FIFO_FORMAT <= SCCFG_FMT_NONE;
         FIFO_WORDS_PER_SAMPLE <= 4'h0;
         FORMAT_RESERVED <= 1'b0;
         SAMPLE_CLOCK_TICK <= 1'b0;
      end else begin
         SAMPLE_START <= start_d;
         FIRST_SLOT_ENABLE <= first_slot_enable;
         FIRST_SLOT_FIFO_FORMAT <= slot_fifo_config_q[SCCFG_FMT_MSB:SCCFG_FMT_LSB];
         // RL1: format decode
         FIFO_WORDS_PER_SAMPLE <= fmt_words(slot_fifo_config_q[SCCFG_FMT_MSB:SCCFG_FMT_LSB]);
         FORMAT_RESERVED <= fmt_reserved(slot_fifo_config_q[SCCFG_FMT_MSB:SCCFG_FMT_LSB]);
         SAMPLE_CLOCK_TICK <= clk32k_tick;
      end
   end
endmodule
`default_nettype wire

// >>> dv/sample_clock_and_slot_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module sample_clock_and_slot_config_test;
   logic MCLK = '0, RESET_N = '0, REG_WR = '0, REG_RD = '0, INT_PIN = '0;
   logic [7:0] REG_ADDR = '0;
   logic [15:0] REG_WDATA = '0;
   wire logic [15:0] REG_RDATA;
   wire logic SAMPLE_START, FIRST_SLOT_ENABLE, FORMAT_RESERVED, SAMPLE_CLOCK_TICK;
   wire logic [2:0] FIRST_SLOT_FIFO_FORMAT;
   wire logic [3:0] FIFO_WORDS_PER_SAMPLE;
   logic [15:0] exq[$];
   logic [31:0] rs = 32'h0000_fc5a;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   sccfg_top dut_u (.MCLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
      .INT_PIN, .SAMPLE_START, .FIRST_SLOT_ENABLE, .FIRST_SLOT_FIFO_FORMAT,
      .FIFO_WORDS_PER_SAMPLE, .FORMAT_RESERVED, .SAMPLE_CLOCK_TICK);
   initial begin
      forever #10 MCLK = ~MCLK;
   end
   // ==================================================
   // helpers
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask
   task automatic wrr(input logic [7:0] a, input logic [15:0] d);
      cy(1);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      cy(1);
      REG_WR = 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a, input logic [15:0] e);
      cy(1);
      REG_ADDR = a;
      REG_RD = 1'b1;
      exq.push_back(e);
      cy(1);
      REG_RD = 1'b0;
   endtask
   task automatic tgap(output int n);
      n = 0;
      do begin
         cy(1);
         n++;
      end while (SAMPLE_CLOCK_TICK !== 1'b1);
   endtask
   task automatic wst(output int k);
      k = 0;
      do begin
         cy(1);
         k += (SAMPLE_CLOCK_TICK === 1'b1);
      end while (SAMPLE_START !== 1'b1);
   endtask
   task automatic idle(input int n, output int ks, output int kt);
      ks = 0;
      kt = 0;
      repeat (n) begin
         cy(1);
         ks += (SAMPLE_START !== 1'b0);
         kt += (SAMPLE_CLOCK_TICK !== 1'b0);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge MCLK) begin
      if (REG_RD === 1'b1) begin
         cy(1);
         chk(REG_RDATA, exq.pop_front());
      end
   end
   always @(posedge MCLK) begin
      cyc++;
      if (cyc == 95000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // ==================================================
   // main sequence
   initial begin
      int n, k, e, t;
      logic [15:0] w;
      cy(16);
      RESET_N = 1'b1;
      wrr(8'h00, 16'hffff);
      rdr(8'h00, 16'h0000);
      rdr(8'h11, 16'h0000);
      rdr(8'h12, 16'h0028);
      rdr(8'h38, 16'h0000);
      rdr(8'h4b, 16'h2612);
      rdr(8'h4d, 16'h425e);
      rdr(8'h4f, 16'h2090);
      $display("reset test done");
      for (int c = 0; c < 8; c++) begin
         wrr(8'h11, 16'({c[2:0], 2'b01}));
         cy(2);
         w = 16'((c == 6) ? 8 : (c == 3 || c == 5 || c == 7) ? 0 : c);
         chk(FIFO_WORDS_PER_SAMPLE, w);
         chk(FORMAT_RESERVED, 16'(w == 0 && c != 0));
         chk(FIRST_SLOT_FIFO_FORMAT, 16'(c));
         chk(FIRST_SLOT_ENABLE, 16'h0001);
      end
      $display("format test done");
      for (int i = 0; i < 4; i++) begin
         t = (i == 0) ? 0 : (i == 1) ? 34 : (i == 2) ? 63 : rnd() % 64;
         w = rnd();
         w = {w[15:8], 1'b1, w[6], 6'(t)};
         wrr(8'h4b, w);
         rdr(8'h4b, w);
         // the first gap after a trim change is partial
         tgap(n);
         tgap(n);
         e = int'(64'h1_0000_0000 / ((524 - 6 * t) * 8589));
         chk(16'(n >= e && n <= e + 1), 16'h0001);
      end
      $display("trim test done");
      wrr(8'h4b, 16'h2622);
      // a tick already in the two-stage pipe may still show
      cy(2);
      idle(4000, k, n);
      chk(16'(k + n), 16'h0000);
      rdr(8'h4b, 16'h2622);
      $display("gate test done");
      wrr(8'h4b, 16'h0080);
      for (int p = 1; p < 3; p++) begin
         wrr(8'h12, 16'(p));
         wst(k);
         wst(k);
         chk(16'(k), 16'(4 * p));
      end
      $display("period test done");
      wrr(8'h11, 16'h0018);
      idle(9000, k, n);
      chk(16'(k), 16'h0000);
      $display("slot test done");
      wrr(8'h4b, 16'h2612);
      wrr(8'h11, 16'h0001);
      for (int g = 0; g < 2; g++) begin
         wrr(8'h4f, g ? 16'h2092 : 16'h2096);
         wrr(8'h38, g ? 16'h0000 : 16'h4000);
         INT_PIN = 1'b1;
         idle(4, k, n);
         chk(16'(k), 16'(1 - g));
         INT_PIN = 1'b0;
         idle(4, k, n);
         chk(16'(k), 16'h0000);
      end
      $display("sync test done");
      end_sim();
   end
endmodule
`default_nettype wire

// >>> dv/sccfg_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module sccfg_top_props (
   // clock, reset and register access
   input wire logic MCLK,
   input wire logic RESET_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_RD,
   input wire logic [15:0] REG_RDATA,
   // sample control
   input wire logic SAMPLE_START,
   input wire logic FIRST_SLOT_ENABLE,
   input wire logic [2:0] FIRST_SLOT_FIFO_FORMAT,
   input wire logic [3:0] FIFO_WORDS_PER_SAMPLE,
   input wire logic SAMPLE_CLOCK_TICK
);
   // ==================================================
   // register mirrors
   logic [15:0] ctrl_q;
   logic [15:0] slot_q;
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl_q <= 16'h2612;
         slot_q <= 16'h0000;
      end else if (REG_WR) begin
         if (REG_ADDR == 8'h4b) ctrl_q <= REG_WDATA;
         if (REG_ADDR == 8'h11) slot_q <= REG_WDATA;
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   // ==================================================
   // properties
   // outputs may lag the register by a cycle, so only a settled mirror is compared
   a_wide_words: assert property (
      $stable(slot_q) && slot_q[4:2] == 3'h6 |-> FIFO_WORDS_PER_SAMPLE == 4'h8)
      else $error("format six not eight words");
   a_fmt_copy: assert property (
      $stable(slot_q) |-> FIRST_SLOT_FIFO_FORMAT == slot_q[4:2])
      else $error("format output differs");
   a_slot_copy: assert property (
      $stable(slot_q) |-> FIRST_SLOT_ENABLE == slot_q[0]) else $error("enable output differs");
   a_slot_idle: assert property (
      !slot_q[0] && $stable(slot_q) |-> !SAMPLE_START) else $error("start with slot off");
   a_gate_stops: assert property (
      !ctrl_q[7] && !$past(ctrl_q[7]) && !$past(ctrl_q[7], 2) |-> !SAMPLE_CLOCK_TICK)
      else $error("tick with gate off");
   a_ctrl_readback: assert property (
      REG_RD && REG_ADDR == 8'h4b |=> REG_RDATA == $past(ctrl_q)) else $error("bad ctrl read");
   a_tick_spacing: assert property (
      $rose(SAMPLE_CLOCK_TICK) |=> !SAMPLE_CLOCK_TICK [*8]) else $error("ticks too close");
   a_start_pulse: assert property (
      SAMPLE_START |=> !SAMPLE_START) else $error("start longer than one cycle");
   c_start: cover property (SAMPLE_START);
   c_tick: cover property (SAMPLE_CLOCK_TICK);
   c_ctrl_read: cover property (REG_RD && REG_ADDR == 8'h4b);
endmodule
bind sccfg_top sccfg_top_props u_props (.MCLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_WDATA,
   .REG_RD, .REG_RDATA, .SAMPLE_START, .FIRST_SLOT_ENABLE, .FIRST_SLOT_FIFO_FORMAT,
   .FIFO_WORDS_PER_SAMPLE, .SAMPLE_CLOCK_TICK);
`default_nettype wire
